// >>> smb_pkg.sv
// Shared constants for the management-bus slave block
package smb_pkg;
	// Timing
	localparam int unsigned CLK_HZ          = 25_000_000;
	localparam int unsigned WRITE_TIME_MS   = 10;
	localparam int unsigned SCR_WRITE_CYCLES = WRITE_TIME_MS * (CLK_HZ / 1000);

	// Sizes
	localparam int unsigned SCR_BYTES = 128;

	// Bus addresses
	localparam logic [6:0] ARA_ADDR = 7'h0c;

	// Thermal sensor command codes
	localparam logic [7:0] CMD_RD_TEMP = 8'h01;
	localparam logic [7:0] CMD_RD_STAT = 8'h02;
	localparam logic [7:0] CMD_RD_CFG  = 8'h03;
	localparam logic [7:0] CMD_RD_RATE = 8'h04;
	localparam logic [7:0] CMD_RD_HIGH = 8'h07;
	localparam logic [7:0] CMD_RD_LOW  = 8'h08;
	localparam logic [7:0] CMD_WR_CFG  = 8'h09;
	localparam logic [7:0] CMD_WR_RATE = 8'h0a;
	localparam logic [7:0] CMD_WR_HIGH = 8'h0d;
	localparam logic [7:0] CMD_WR_LOW  = 8'h0e;
	localparam logic [7:0] CMD_ONESHOT = 8'h0f;
	localparam logic [7:0] CMD_RESET   = 8'h00;

	// Thermal sensor reset values
	localparam logic [7:0] CFG_RESET  = 8'h00;
	localparam logic [7:0] RATE_RESET = 8'h02;
	localparam logic [7:0] HIGH_RESET = 8'h7f;
	localparam logic [7:0] LOW_RESET  = 8'hc9;
	localparam logic [7:0] TEMP_RESET = 8'h00;

	// Field positions
	localparam int unsigned CFG_RUN_STOP = 6;
	localparam int unsigned STAT_BUSY    = 7;
	localparam int unsigned STAT_HIGH    = 4;
	localparam int unsigned STAT_LOW     = 3;
	localparam int unsigned STAT_OPEN    = 2;

	// Protocol state
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK
	} smb_state_t;

	// Addressed target
	typedef enum logic [2:0] {
		TG_NONE, TG_ROM, TG_SCR, TG_TS, TG_ARA
	} smb_tgt_t;
endpackage

// >>> smb_mem.sv
// Scratch memory: byte storage, address pointer and self-timed write
`timescale 1ns/1ps
`default_nettype none
module smb_mem #(
	parameter int unsigned WRITE_CYCLES = smb_pkg::SCR_WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// Pointer control
	input  wire logic       ptr_load,
	input  wire logic [6:0] ptr_val,
	input  wire logic       ptr_inc,
	// Write path
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	input  wire logic       busy_start,
	// Read path and status
	output logic      [7:0] rdata,
	output logic            busy
);
	import smb_pkg::*;

	localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);

	logic [7:0]    mem [SCR_BYTES];
	logic [6:0]    ptr;
	logic [CW-1:0] busy_cnt;

	// Pointer follows the last access plus one and wraps
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ptr <= 7'h00;
		end else if (ptr_load) begin
			ptr <= ptr_val;
		end else if (wr_en || ptr_inc) begin
			ptr <= ptr + 7'h01;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SCR_BYTES; gi++) begin : g_byte
			always_ff @(posedge mclk or posedge sys_rst) begin
				if (sys_rst) begin
					mem[gi] <= 8'h00;
				end else if (wr_en && ptr == 7'(gi)) begin
					mem[gi] <= wr_data;
				end
			end
		end
	endgenerate

	assign rdata = mem[ptr];

	// Self-timed write period
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_cnt <= '0;
		end else if (busy_start) begin
			busy_cnt <= CW'(WRITE_CYCLES);
		end else if (busy_cnt != '0) begin
			busy_cnt <= busy_cnt - CW'(1);
		end
	end

	assign busy = (busy_cnt != '0);
endmodule
`default_nettype wire

// >>> smb_slave.sv
// Management-bus slave: info ROM, scratch memory and thermal sensor
`timescale 1ns/1ps
`default_nettype none
module smb_slave #(
	parameter logic [6:0]  ROM_ADDR         = 7'h50,
	parameter logic [6:0]  SCR_ADDR         = 7'h51,
	parameter logic [6:0]  TS_ADDR          = 7'h18,
	parameter int unsigned SCR_WRITE_CYCLES = smb_pkg::SCR_WRITE_CYCLES
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// Bus pins
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	output logic            alert_out,
	output logic            alert_oe_n,
	// Info ROM storage
	output logic      [7:0] rom_index,
	input  wire logic [7:0] rom_rdata,
	// Converter side
	input  wire logic [7:0] temp_in,
	input  wire logic       temp_valid,
	input  wire logic       conv_busy,
	input  wire logic       open_fault,
	output logic            one_shot,
	output logic            run_stop,
	output logic      [7:0] conv_rate
);
	import smb_pkg::*;

	smb_state_t state;
	smb_tgt_t   tgt;
	logic       scl_q, scl_p, sda_q, sda_p;
	logic       scl_rise, scl_fall, start_cond, stop_cond;
	logic [3:0] bitcnt;
	logic [7:0] shreg, txsh, tx_byte;
	logic [1:0] nbytes;
	logic       rd_dir;
	logic [7:0] ts_cmd, cfg, high_lim, low_lim, temp;
	logic       hi_flag, lo_flag, ara_done, scr_wr_pend;
	logic       hi_now, lo_now, stat_read, byte_done;
	logic       scr_ptr_load, scr_wr, scr_ptr_inc, scr_busy_start, scr_busy;
	logic [7:0] scr_rdata;

	// Returns the sensor register that a read command selects
	function automatic logic [7:0] ts_read(input logic [7:0] cmd, input logic [7:0] stat);
		logic [7:0] v;
		v = 8'h00;
		unique case (cmd)
			CMD_RD_TEMP: v = temp;
			CMD_RD_STAT: v = stat;
			CMD_RD_CFG:  v = cfg;
			CMD_RD_RATE: v = conv_rate;
			CMD_RD_HIGH: v = high_lim;
			CMD_RD_LOW:  v = low_lim;
			default:     v = 8'h00;
		endcase
		return v;
	endfunction

	// Input sampling and bus condition detect
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			scl_p <= 1'b1;
			sda_q <= 1'b1;
			sda_p <= 1'b1;
		end else begin
			scl_q <= scl_in;
			scl_p <= scl_q;
			sda_q <= sda_in;
			sda_p <= sda_q;
		end
	end

	assign scl_rise   = scl_q & ~scl_p;
	assign scl_fall   = ~scl_q & scl_p;
	assign start_cond = scl_q & scl_p & sda_p & ~sda_q;
	assign stop_cond  = scl_q & scl_p & ~sda_p & sda_q;

	// Byte to transmit for the current target
	always_comb begin
		tx_byte = 8'hff;
		unique case (tgt)
			TG_ROM: tx_byte = rom_rdata;
			TG_SCR: tx_byte = scr_rdata;
			// receive returns register of last command byte, 00 for a non-read command
			TG_TS:  tx_byte = ts_read(ts_cmd, {conv_busy, 2'b00, hi_flag, lo_flag, open_fault, 2'b00});
			// own address in upper seven bits
			TG_ARA: tx_byte = {TS_ADDR, 1'b1};
			TG_NONE: tx_byte = 8'hff;
		endcase
	end

	// Read byte delivered to the host
	assign byte_done = scl_fall && state == ST_RD && bitcnt == 4'h8;
	assign stat_read = byte_done && tgt == TG_TS && ts_cmd == CMD_RD_STAT;

	// Protocol engine
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state    <= ST_IDLE;
			tgt      <= TG_NONE;
			bitcnt   <= 4'h0;
			shreg    <= 8'h00;
			txsh     <= 8'hff;
			rd_dir   <= 1'b0;
			nbytes   <= 2'h0;
			sda_oe_n <= 1'b1;
		end else if (start_cond) begin
			state    <= ST_ADDR;
			bitcnt   <= 4'h0;
			nbytes   <= 2'h0;
			sda_oe_n <= 1'b1;
		end else if (stop_cond) begin
			state    <= ST_IDLE;
			tgt      <= TG_NONE;
			sda_oe_n <= 1'b1;
		end else if (scl_rise) begin
			if (state == ST_ADDR || state == ST_WR || state == ST_RD) begin
				shreg  <= {shreg[6:0], sda_q};
				bitcnt <= bitcnt + 4'h1;
			end else if (state == ST_RACK) begin
				shreg  <= {shreg[6:0], sda_q};
			end
		end else if (scl_fall) begin
			unique case (state)
				ST_IDLE: begin
					sda_oe_n <= 1'b1;
				end
				ST_ADDR: begin
					if (bitcnt == 4'h8) begin
						rd_dir <= shreg[0];
						bitcnt <= 4'h0;
						state  <= ST_AACK;
						sda_oe_n <= 1'b0;
						if (shreg[7:1] == SCR_ADDR && !scr_busy) begin
							tgt <= TG_SCR;
						end else if (shreg[7:1] == ROM_ADDR) begin
							tgt <= TG_ROM;
						end else if (shreg[7:1] == TS_ADDR) begin
							tgt <= TG_TS;
						// answer alert response only if alerting
						end else if (shreg[7:1] == ARA_ADDR && shreg[0] && (hi_flag || lo_flag) && !ara_done) begin
							tgt <= TG_ARA;
						end else begin
							tgt      <= TG_NONE;
							state    <= ST_IDLE;
							sda_oe_n <= 1'b1;
						end
					end
				end
				ST_AACK: begin
					bitcnt <= 4'h0;
					if (rd_dir) begin
						state    <= ST_RD;
						txsh     <= tx_byte;
						sda_oe_n <= tx_byte[7];
					end else begin
						state    <= ST_WR;
						sda_oe_n <= 1'b1;
					end
				end
				ST_WR: begin
					if (bitcnt == 4'h8) begin
						bitcnt <= 4'h0;
						state  <= ST_WACK;
						if (nbytes != 2'h3) begin
							nbytes <= nbytes + 2'h1;
						end
						// sensor acknowledges command and data bytes
						// acknowledge offset and data; ROM refuses data
						if (nbytes == 2'h0 || (nbytes == 2'h1 && (tgt == TG_SCR || tgt == TG_TS))) begin
							sda_oe_n <= 1'b0;
						end else begin
							sda_oe_n <= 1'b1;
						end
					end
				end
				ST_WACK: begin
					state    <= ST_WR;
					sda_oe_n <= 1'b1;
				end
				ST_RD: begin
					if (bitcnt == 4'h8) begin
						state    <= ST_RACK;
						sda_oe_n <= 1'b1;
					end else begin
						txsh     <= {txsh[6:0], 1'b1};
						sda_oe_n <= txsh[6];
					end
				end
				ST_RACK: begin
					bitcnt <= 4'h0;
					if (shreg[0]) begin
						state    <= ST_IDLE;
						sda_oe_n <= 1'b1;
					end else begin
						state    <= ST_RD;
						txsh     <= tx_byte;
						sda_oe_n <= tx_byte[7];
					end
				end
			endcase
		end
	end

	// Accepted write byte strobes
	logic wr_byte;
	assign wr_byte = scl_fall && state == ST_WR && bitcnt == 4'h8;

	// send byte loads the pointer only
	assign scr_ptr_load = wr_byte && tgt == TG_SCR && nbytes == 2'h0;
	assign scr_wr       = wr_byte && tgt == TG_SCR && nbytes == 2'h1;
	assign scr_ptr_inc  = byte_done && tgt == TG_SCR;

	// ROM pointer load; advance with wrap
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			rom_index <= 8'h00;
		end else if (wr_byte && tgt == TG_ROM && nbytes == 2'h0) begin
			rom_index <= shreg;
		end else if (byte_done && tgt == TG_ROM) begin
			rom_index <= rom_index + 8'h01;
		end
	end

	// timed write begins at the stop after the data byte
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			scr_wr_pend <= 1'b0;
		end else if (scr_wr) begin
			scr_wr_pend <= 1'b1;
		end else if (stop_cond || start_cond) begin
			scr_wr_pend <= 1'b0;
		end
	end

	assign scr_busy_start = stop_cond && scr_wr_pend;

	// repeated start keeps the loaded pointer for the read
	smb_mem #(
		.WRITE_CYCLES(SCR_WRITE_CYCLES)
	) u_scr (
		.mclk       (mclk),
		.sys_rst    (sys_rst),
		.ptr_load   (scr_ptr_load),
		.ptr_val    (shreg[6:0]),
		.ptr_inc    (scr_ptr_inc),
		.wr_en      (scr_wr),
		.wr_data    (shreg),
		.busy_start (scr_busy_start),
		.rdata      (scr_rdata),
		.busy       (scr_busy)
	);

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ts_cmd    <= CMD_RESET;
			cfg       <= CFG_RESET;
			conv_rate <= RATE_RESET;
			high_lim  <= HIGH_RESET;
			low_lim   <= LOW_RESET;
		end else if (wr_byte && tgt == TG_TS) begin
			if (nbytes == 2'h0) begin
				ts_cmd <= shreg;
			end else if (nbytes == 2'h1) begin
				unique case (ts_cmd)
					CMD_WR_CFG:  cfg <= shreg;
					CMD_WR_RATE: conv_rate <= shreg;
					CMD_WR_HIGH: high_lim <= shreg;
					CMD_WR_LOW:  low_lim <= shreg;
					default:     cfg <= cfg;
				endcase
			end
		end
	end

	logic ts_send;
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ts_send  <= 1'b0;
			one_shot <= 1'b0;
			run_stop <= 1'b0;
		end else begin
			if (start_cond) begin
				ts_send <= 1'b0;
			end else if (wr_byte && tgt == TG_TS) begin
				ts_send <= (nbytes == 2'h0);
			end
			one_shot <= stop_cond && ts_send && ts_cmd == CMD_ONESHOT;
			run_stop <= cfg[CFG_RUN_STOP];
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			temp <= TEMP_RESET;
		end else if (temp_valid) begin
			temp <= temp_in;
		end
	end

	assign hi_now = $signed(temp) >= $signed(high_lim);
	assign lo_now = $signed(temp) <= $signed(low_lim);

	// sticky flags, a set beats the status-read clear
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			hi_flag <= 1'b0;
			lo_flag <= 1'b0;
		end else begin
			hi_flag <= hi_now || (hi_flag && !stat_read);
			lo_flag <= lo_now || (lo_flag && !stat_read);
		end
	end

	// alert released once the response address read is answered
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ara_done <= 1'b0;
		end else if (byte_done && tgt == TG_ARA) begin
			ara_done <= 1'b1;
		end else if (!hi_flag && !lo_flag) begin
			ara_done <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			alert_oe_n <= 1'b1;
			alert_out  <= 1'b0;
			sda_out    <= 1'b0;
		end else begin
			alert_oe_n <= !((hi_flag || lo_flag) && !ara_done);
			alert_out  <= 1'b0;
			sda_out    <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> smb_props.sv
// Port-level assertions for the management-bus slave
`timescale 1ns/1ps
`default_nettype none
module smb_props (
	// Clock and reset
	input wire logic       mclk,
	input wire logic       sys_rst,
	// Bus pins
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       sda_out,
	input wire logic       sda_oe_n,
	input wire logic       alert_out,
	// Storage and converter side
	input wire logic [7:0] rom_index,
	input wire logic       one_shot,
	input wire logic [7:0] conv_rate
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	chk_sda_open_drain: assert property (sda_out == 1'b0) else $error("data output not low");
	chk_alert_open_drain: assert property (alert_out == 1'b0) else $error("alert output not low");
	chk_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
		else $error("data drive changed with clock high");
	chk_ack_bit_holds: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*5])
		else $error("driven low bit too short");
	chk_one_shot_pulse: assert property (one_shot |=> !one_shot) else $error("one-shot too long");
	chk_one_shot_idle: assert property (one_shot |-> scl_in && sda_in)
		else $error("one-shot before stop");
	chk_rom_ptr_low: assert property ($changed(rom_index) |-> !scl_in)
		else $error("pointer moved with clock high");
	chk_rate_write_low: assert property ($changed(conv_rate) |-> !scl_in)
		else $error("rate changed with clock high");
endmodule
bind smb_slave smb_props smb_props_i (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out), .rom_index(rom_index),
	.one_shot(one_shot), .conv_rate(conv_rate));
`default_nettype wire

// >>> smb_host.sv
// Bus host model driving clock and data toward the slave
`timescale 1ns/1ps
`default_nettype none
module smb_host (
	// Clock and wired data level
	input  wire logic mclk,
	input  wire logic sda_w,
	// Driven lines, pulled up when released
	output logic      scl_o,
	output logic      sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		sda_o <= b;
		repeat (3) @(posedge mclk);
		scl_o <= 1'b1;
		repeat (5) @(posedge mclk);
		r = sda_w;
		scl_o <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	// start is data falling under high clock
	task automatic start();
		sda_o <= 1'b1;
		repeat (3) @(posedge mclk);
		scl_o <= 1'b1;
		repeat (5) @(posedge mclk);
		sda_o <= 1'b0;
		repeat (5) @(posedge mclk);
		scl_o <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	// stop is data rising under high clock
	task automatic stop();
		sda_o <= 1'b0;
		repeat (3) @(posedge mclk);
		scl_o <= 1'b1;
		repeat (5) @(posedge mclk);
		sda_o <= 1'b1;
		repeat (5) @(posedge mclk);
	endtask
	// host drives address, direction and write bytes
	task automatic wbyte(input logic [7:0] v, output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(v[i], r);
		bit_io(1'b1, ak);
	endtask
	// read byte released, host closes with the acknowledge bit nk
	task automatic rbyte(input logic nk, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
		bit_io(nk, r);
	endtask
endmodule
`default_nettype wire

// >>> smb_slave_tb.sv
// Self-checking bench for the management-bus slave
`timescale 1ns/1ps
`default_nettype none
module smb_slave_tb;
	import smb_pkg::*;
	`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; \
		$display("[FAIL] %0t got %h want %h", $time, g, e); end end
	localparam logic [6:0] ROM_A = 7'h50;
	localparam logic [6:0] SCR_A = 7'h51;
	localparam logic [6:0] TS_A  = 7'h18;
	localparam int         WCYC  = 400;
	logic       mclk, sys_rst, scl, h_sda, sda_w, sda_out, sda_oe_n, alert_out, alert_oe_n;
	logic       one_shot, run_stop, temp_valid, conv_busy, open_fault, a;
	logic [7:0] rom_index, rom_rdata, temp_in, conv_rate, d;
	logic [2:0] ak;
	int         bad_count, checks, cyc, os_cnt;
	assign sda_w = h_sda & (sda_oe_n | sda_out);
	assign rom_rdata = rom_index ^ 8'h5a;
	smb_slave #(.SCR_WRITE_CYCLES(WCYC)) smb_slave_i (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl),
		.sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .alert_out(alert_out),
		.alert_oe_n(alert_oe_n), .rom_index(rom_index), .rom_rdata(rom_rdata), .temp_in(temp_in),
		.temp_valid(temp_valid), .conv_busy(conv_busy), .open_fault(open_fault), .one_shot(one_shot),
		.run_stop(run_stop), .conv_rate(conv_rate));
	smb_host smb_host_i (.mclk(mclk), .sda_w(sda_w), .scl_o(scl), .sda_o(h_sda));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (one_shot === 1'b1) os_cnt++;
		if (cyc == 30000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic tx(input logic [6:0] ad, input logic [7:0] b0, b1, input int n, input logic stp);
		ak = 3'b111;
		smb_host_i.start();
		smb_host_i.wbyte({ad, 1'b0}, ak[0]);
		if (n > 0) smb_host_i.wbyte(b0, ak[1]);
		if (n > 1) smb_host_i.wbyte(b1, ak[2]);
		if (stp) smb_host_i.stop();
	endtask
	task automatic rx(input logic [6:0] ad);
		smb_host_i.start();
		smb_host_i.wbyte({ad, 1'b1}, a);
		smb_host_i.rbyte(1'b1, d);
		smb_host_i.stop();
	endtask
	// Offset write, repeated start, then current-address read
	task automatic rd(input logic [6:0] ad, input logic [7:0] c);
		tx(ad, c, 8'h00, 1, 1'b0);
		rx(ad);
	endtask
	task automatic temp(input logic [7:0] v);
		temp_in <= v;
		temp_valid <= 1'b1;
		@(posedge mclk);
		temp_valid <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	task automatic t_scratch();
		tx(SCR_A, 8'h00, 8'h3c, 2, 1'b1);
		`CHK(ak, 3'b000)
		rx(SCR_A);
		`CHK(a, 1'b1)
		repeat (WCYC + 10) @(posedge mclk);
		tx(SCR_A, 8'h7f, 8'ha5, 2, 1'b1);
		`CHK(ak, 3'b000)
		repeat (WCYC + 10) @(posedge mclk);
		tx(SCR_A, 8'h7f, 8'h00, 1, 1'b1);
		`CHK(ak[1:0], 2'b00)
		rx(SCR_A);
		`CHK({a, d}, {1'b0, 8'ha5})
		rx(SCR_A);
		`CHK(d, 8'h3c)
	endtask
	task automatic t_rom();
		tx(ROM_A, 8'h10, 8'h77, 2, 1'b1);
		`CHK(ak, 3'b100)
		tx(ROM_A, 8'hfe, 8'h00, 1, 1'b1);
		for (int i = 0; i < 3; i++) begin
			rx(ROM_A);
			`CHK(d, (8'hfe + 8'(i)) ^ 8'h5a)
		end
		rd(ROM_A, 8'h21);
		`CHK({a, d}, {1'b0, 8'h21 ^ 8'h5a})
		rx(7'h33);
		`CHK(a, 1'b1)
	endtask
	task automatic t_sensor();
		logic [7:0] cm [5] = '{CMD_RD_HIGH, CMD_RD_LOW, CMD_RD_CFG, CMD_RD_RATE, 8'h05};
		logic [7:0] ev [5] = '{8'h10, 8'hf0, 8'h40, 8'h05, 8'h00};
		tx(TS_A, CMD_WR_HIGH, 8'h10, 2, 1'b1);
		`CHK(ak, 3'b000)
		tx(TS_A, CMD_WR_LOW, 8'hf0, 2, 1'b1);
		tx(TS_A, CMD_WR_CFG, 8'h40, 2, 1'b1);
		tx(TS_A, CMD_WR_RATE, 8'h05, 2, 1'b1);
		`CHK({run_stop, conv_rate}, {1'b1, 8'h05})
		for (int i = 0; i < 5; i++) begin
			rd(TS_A, cm[i]);
			`CHK({a, d}, {1'b0, ev[i]})
		end
		rx(TS_A);
		`CHK(d, 8'h00)
		rd(TS_A, CMD_RD_RATE);
		rx(TS_A);
		`CHK({a, d}, {1'b0, 8'h05})
	endtask
	task automatic t_alarm();
		`CHK(alert_oe_n, 1'b1)
		temp(8'h10);
		`CHK(alert_oe_n, 1'b0)
		rd(TS_A, CMD_RD_TEMP);
		`CHK(d, 8'h10)
		rx(ARA_ADDR);
		`CHK({a, d}, {1'b0, TS_A, 1'b1})
		`CHK(alert_oe_n, 1'b1)
		rx(ARA_ADDR);
		`CHK(a, 1'b1)
		temp(8'he0);
		rd(TS_A, CMD_RD_STAT);
		`CHK(d, 8'h9c)
		rd(TS_A, CMD_RD_STAT);
		`CHK(d, 8'h8c)
	endtask
	task automatic t_oneshot();
		os_cnt = 0;
		tx(TS_A, CMD_ONESHOT, 8'h00, 1, 1'b1);
		repeat (4) @(posedge mclk);
		`CHK(os_cnt, 1)
		tx(TS_A, CMD_ONESHOT, 8'h00, 2, 1'b1);
		repeat (4) @(posedge mclk);
		`CHK(os_cnt, 1)
	endtask
	initial begin
		sys_rst = 1'b1;
		temp_in = 8'h00;
		temp_valid = 1'b0;
		conv_busy = 1'b1;
		open_fault = 1'b1;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge mclk);
		`CHK({sda_oe_n, alert_oe_n, run_stop, conv_rate, rom_index}, {3'b110, RATE_RESET, 8'h00})
		t_scratch();
		t_rom();
		t_sensor();
		t_alarm();
		t_oneshot();
		final_report();
	end
endmodule
`default_nettype wire
